// File: rtl/sasc_map.svh
// Offsets, field positions, reset values and timing counts of the converter.
// What this block does
// R1 - Resolve each sample to 8 bits by approximation
// R2 - Start bit begins conversion, then clears itself
// R3 - Start during conversion aborts and restarts
// R4 - Software waits for done before restarting
// R5 - Mode field: stop, software, trigger, reserved
// R6 - Analog input control bit disables inputs when one
// R7 - Channel field picks one of six inputs
// R8 - Software changes channel only when stopped
// R9 - Trigger mode accepts first trigger only
// R10 - Trigger converts selected channel into result
// R11 - Time field sets 156 to 1248 clocks
// R12 - Software writes fixed bits in control two
// R13 - Software mode converts once per start
// R14 - Conversion end sets done and interrupt together
// R15 - Reading result clears the done flag
// R16 - Restart clears done, keeps previous result
// R17 - Stop mode halts at once, no partial result
// R18 - Stop mode ignores every start command
// R19 - Reset places converter in stop mode
// R20 - Standby stop reinitializes control register one
// R21 - Standby aborts conversion, no done follows
// R22 - Trigger passes only when generation is enabled
// R23 - Trigger is edge sensitive, synchronized
`ifndef SASC_MAP_SVH
`define SASC_MAP_SVH

// ******************************
// Register byte addresses.
// ******************************
`define SASC_ADDR_CTL_ONE 8'h0e
`define SASC_ADDR_CTL_TWO 8'h0f
`define SASC_ADDR_RESULT 8'h10
`define SASC_ADDR_STATUS 8'h11

// ******************************
// Reset values and fields.
// ******************************
`define SASC_CTL_ONE_RST 8'h10
`define SASC_CTL_TWO_RST 8'h10
`define SASC_CTL_TWO_MASK 8'h3f
`define SASC_TIME_LSB 1
`define SASC_STAT_DONE 5
`define SASC_STAT_BUSY 4
`define SASC_TIME_156 3'h3
`define SASC_TIME_312 3'h4
`define SASC_TIME_624 3'h5

// ******************************
// Conversion lengths in fast clock periods.
// ******************************
`define SASC_LEN_156 156
`define SASC_LEN_312 312
`define SASC_LEN_624 624
`define SASC_LEN_1248 1248
`define SASC_STEPS 13
`define SASC_SAMPLE_STEPS 4'h5
`define SASC_LAST_STEP 4'hc

`endif

// File: rtl/sasc_pkg.sv
// Types shared by the converter sequencer.
package sasc_pkg;

  typedef enum logic [1:0] {
    SASC_MODE_STOP = 2'h0,
    SASC_MODE_SOFT = 2'h1,
    SASC_MODE_TRIG = 2'h2,
    SASC_MODE_RSVD = 2'h3
  } sasc_mode_t;

  typedef struct packed {
    logic start;
    sasc_mode_t mode;
    logic ain_disable;
    logic zero_bit;
    logic [2:0] channel;
  } sasc_ctl_t;

  typedef enum logic [2:0] {
    SASC_ST_IDLE = 3'b001,
    SASC_ST_SAMPLE = 3'b010,
    SASC_ST_BITS = 3'b100
  } sasc_state_t;

endpackage

// File: rtl/sasc_top.sv
// Sequencer, registers and approximation logic of the 8-bit converter.
`timescale 1ns/1ps
`include "sasc_map.svh"

module sasc_top (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // System and wake-up circuit.
  input wire logic standby_stop,
  input wire logic wake_trigger_out,
  input wire logic trigger_gen_enable,
  // Analog front end.
  input wire logic cmp_above,
  output logic [7:0] dac_code,
  output logic sample_hold,
  output logic [2:0] channel_select,
  output logic channel_valid,
  output logic analog_in_disable,
  // Status.
  output logic conv_busy,
  output logic conv_done_irq
);

  // ******************************
  // Registers.
  // ******************************
  sasc_pkg::sasc_ctl_t ctl_one;
  logic [7:0] ctl_two;
  logic [7:0] conversion_result;
  logic conv_done_flag;
  sasc_pkg::sasc_state_t state;
  logic [3:0] step_idx;
  logic [6:0] step_cnt;
  logic [6:0] step_len;
  logic [7:0] sar;
  logic [2:0] bit_idx;
  logic armed;
  logic trg_s1;
  logic trg_s2;
  logic trg_s3;
  logic trg_lvl;
  logic trg_prev;
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_s3;
  logic cmp_lvl;

  logic wr_one;
  logic rd_result;
  logic trig_edge;
  logic soft_go;
  logic trig_go;
  logic go;
  logic stop_now;
  logic step_end;
  logic finish;
  logic busy;

  assign busy = (state != sasc_pkg::SASC_ST_IDLE);
  assign wr_one = reg_wr && (reg_addr == `SASC_ADDR_CTL_ONE);
  assign rd_result = reg_rd && (reg_addr == `SASC_ADDR_RESULT);

  // ******************************
  // Start decisions.
  // ******************************
  // Modes other than software and trigger count as stop.
  assign stop_now = standby_stop || // [R21]
    (ctl_one.mode == sasc_pkg::SASC_MODE_STOP) ||
    (ctl_one.mode == sasc_pkg::SASC_MODE_RSVD); // [R5] [R17]

  assign soft_go = ctl_one.start &&
    (ctl_one.mode == sasc_pkg::SASC_MODE_SOFT); // [R13] [R18]

  assign trig_go = trig_edge && armed &&
    (ctl_one.mode == sasc_pkg::SASC_MODE_TRIG); // [R9] [R10] [R18]

  assign go = !standby_stop && (soft_go || trig_go); // [R3]

  // ******************************
  // Control register one.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset || standby_stop) begin
      ctl_one <= sasc_pkg::sasc_ctl_t'(`SASC_CTL_ONE_RST); // [R19] [R20]
    end else if (wr_one) begin
      ctl_one <= sasc_pkg::sasc_ctl_t'(reg_wdata);
    end else if (ctl_one.start) begin
      // Cleared once the start has been acted on or ignored.
      ctl_one.start <= 1'b0; // [R2]
    end
  end

  // ******************************
  // Control register two.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset || standby_stop) begin
      ctl_two <= `SASC_CTL_TWO_RST;
    end else if (reg_wr && (reg_addr == `SASC_ADDR_CTL_TWO)) begin
      ctl_two <= reg_wdata & `SASC_CTL_TWO_MASK;
    end
  end

  // Reserved time codes fall back to the longest, safest length.
  always_comb begin
    case (ctl_two[`SASC_TIME_LSB +: 3])
      `SASC_TIME_156: step_len = 7'(`SASC_LEN_156 / `SASC_STEPS); // [R11]
      `SASC_TIME_312: step_len = 7'(`SASC_LEN_312 / `SASC_STEPS); // [R11]
      `SASC_TIME_624: step_len = 7'(`SASC_LEN_624 / `SASC_STEPS); // [R11]
      default: step_len = 7'(`SASC_LEN_1248 / `SASC_STEPS); // [R11]
    endcase
  end

  // ******************************
  // Trigger synchronizer and edge.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      trg_s1 <= 1'b0;
      trg_s2 <= 1'b0;
      trg_s3 <= 1'b0;
      trg_lvl <= 1'b0;
      trg_prev <= 1'b0;
    end else begin
      trg_s1 <= wake_trigger_out;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
      if (trg_s2 == trg_s3) begin
        trg_lvl <= trg_s3; // [R23]
      end
      trg_prev <= trg_lvl;
    end
  end

  assign trig_edge = trg_lvl && !trg_prev && trigger_gen_enable; // [R22] [R23]

  // Set only while stopped and cleared by a taken trigger, so a second trigger needs a pass through stop.
  always_ff @(posedge mclk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (ctl_one.mode == sasc_pkg::SASC_MODE_STOP) begin
      armed <= 1'b1; // [R9]
    end else if (trig_go) begin
      armed <= 1'b0; // [R9]
    end
  end

  // ******************************
  // Comparator synchronizer.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_lvl <= 1'b0;
    end else begin
      cmp_s1 <= cmp_above;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3) begin
        cmp_lvl <= cmp_s3;
      end
    end
  end

  // ******************************
  // Sequencer.
  // ******************************
  assign step_end = busy && (step_cnt == step_len - 7'h1);
  assign finish = step_end && (state == sasc_pkg::SASC_ST_BITS) &&
    (bit_idx == 3'h0) && !stop_now && !go;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= sasc_pkg::SASC_ST_IDLE;
      step_idx <= 4'h0;
      step_cnt <= 7'h0;
    end else if (stop_now) begin
      state <= sasc_pkg::SASC_ST_IDLE; // [R17] [R21]
      step_idx <= 4'h0;
      step_cnt <= 7'h0;
    end else if (go) begin
      state <= sasc_pkg::SASC_ST_SAMPLE; // [R3] [R13]
      step_idx <= 4'h0;
      step_cnt <= 7'h0;
    end else if (step_end) begin
      step_cnt <= 7'h0;
      step_idx <= step_idx + 4'h1;
      case (state)
        sasc_pkg::SASC_ST_SAMPLE: begin
          if (step_idx == `SASC_SAMPLE_STEPS - 4'h1) begin
            state <= sasc_pkg::SASC_ST_BITS;
          end
        end
        sasc_pkg::SASC_ST_BITS: begin
          if (step_idx == `SASC_LAST_STEP) begin
            state <= sasc_pkg::SASC_ST_IDLE;
          end
        end
        default: begin
          state <= sasc_pkg::SASC_ST_IDLE;
        end
      endcase
    end else if (busy) begin
      step_cnt <= step_cnt + 7'h1;
    end
  end

  // ******************************
  // Successive approximation.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      sar <= 8'h00;
      bit_idx <= 3'h7;
    end else if (go || state != sasc_pkg::SASC_ST_BITS) begin
      sar <= 8'h80;
      bit_idx <= 3'h7;
    end else if (step_end) begin
      // Keep the trial bit only if the input lies above the ladder.
      sar[bit_idx] <= cmp_lvl; // [R1]
      if (bit_idx != 3'h0) begin
        sar[bit_idx - 3'h1] <= 1'b1; // [R1]
        bit_idx <= bit_idx - 3'h1;
      end
    end
  end

  // The result only moves on a full conversion, never on an abort.
  always_ff @(posedge mclk) begin
    if (reset) begin
      conversion_result <= 8'h00;
    end else if (finish) begin
      conversion_result <= {sar[7:1], cmp_lvl}; // [R10] [R13] [R17]
    end
  end

  // ******************************
  // Done flag and request.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      conv_done_flag <= 1'b0;
    end else if (finish) begin
      conv_done_flag <= 1'b1; // [R14]
    end else if (go || rd_result || standby_stop) begin
      conv_done_flag <= 1'b0; // [R15] [R16] [R21]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= finish; // [R14]
    end
  end

  // ******************************
  // Read port.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `SASC_ADDR_CTL_ONE) begin
      reg_rdata <= ctl_one;
    end else if (reg_addr == `SASC_ADDR_CTL_TWO) begin
      reg_rdata <= ctl_two;
    end else if (reg_addr == `SASC_ADDR_RESULT) begin
      reg_rdata <= conversion_result;
    end else if (reg_addr == `SASC_ADDR_STATUS) begin
      reg_rdata <= 8'h00;
      reg_rdata[`SASC_STAT_DONE] <= conv_done_flag;
      reg_rdata[`SASC_STAT_BUSY] <= busy;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ******************************
  // Front end outputs.
  // ******************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      dac_code <= 8'h00;
      sample_hold <= 1'b0;
      channel_select <= 3'h0;
      channel_valid <= 1'b0;
      analog_in_disable <= 1'b1;
      conv_busy <= 1'b0;
    end else begin
      dac_code <= sar;
      sample_hold <= (state == sasc_pkg::SASC_ST_SAMPLE);
      channel_select <= ctl_one.channel; // [R7]
      channel_valid <= (ctl_one.channel < 3'h6) && !ctl_one.ain_disable; // [R6] [R7]
      analog_in_disable <= ctl_one.ain_disable; // [R6]
      conv_busy <= busy;
    end
  end

  // ******************************
  // Checks.
  // ******************************
  logic [10:0] conv_cycles;

  always_ff @(posedge mclk) begin
    if (reset || go) begin
      conv_cycles <= 11'h0;
    end else if (busy) begin
      conv_cycles <= conv_cycles + 11'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_start_self_clear: assert property ( // [R2]
    ctl_one.start && !wr_one |=> !ctl_one.start)
    else $error("start bit did not clear");

  a_stop_ignores_start: assert property ( // [R18]
    stop_now |=> state == sasc_pkg::SASC_ST_IDLE)
    else $error("conversion ran in stop mode");

  a_done_with_irq: assert property ( // [R14]
    $rose(conv_done_flag) |-> conv_done_irq)
    else $error("done flag without request");

  a_read_clears_done: assert property ( // [R15]
    rd_result && !finish |=> !conv_done_flag)
    else $error("result read kept done flag");

  a_result_only_final: assert property ( // [R17]
    !finish |=> $stable(conversion_result))
    else $error("result changed outside finish");

  a_restart_aborts: assert property ( // [R3]
    busy && go |=> state == sasc_pkg::SASC_ST_SAMPLE && step_idx == 4'h0)
    else $error("restart did not restart");

  a_restart_clears_done: assert property ( // [R16]
    go && !finish |=> !conv_done_flag)
    else $error("restart kept done flag");

  a_conv_length: assert property ( // [R11]
    finish |-> conv_cycles == (11'(step_len) * 11'(`SASC_STEPS)) - 11'h1)
    else $error("conversion length wrong");

  a_standby_reinit: assert property ( // [R20]
    standby_stop |=> ctl_one == sasc_pkg::sasc_ctl_t'(`SASC_CTL_ONE_RST) && !busy)
    else $error("standby did not reinitialize");

  a_trigger_once: assert property ( // [R9]
    trig_go |=> !armed ##1 !trig_go)
    else $error("second trigger accepted");

  c_soft_done: cover property (
    soft_go ##[1:1000] finish);

  c_trig_done: cover property (
    trig_go ##[1:1000] finish);

  c_stop_abort: cover property (
    busy && stop_now && !standby_stop);

endmodule // sasc_top

// File: verification/sasc_afe_model.sv
// Behavioural comparator, sample-hold and ladder on the converter's far side.
`timescale 1ns/1ps

module sasc_afe_model (
  // Clock.
  input wire logic mclk,
  // Levels of the six inputs, input zero in the low byte.
  input wire logic [47:0] ain_levels,
  // Converter side.
  input wire logic [7:0] dac_code,
  input wire logic sample_hold,
  input wire logic [2:0] channel_select,
  input wire logic channel_valid,
  output logic cmp_above
);
  logic [7:0] held;
  logic [5:0] lsb;
  initial held = 8'h00;
  assign lsb = {channel_select, 3'b000};
  // A disabled or unselected input leaves the hold node at ground.
  always @(posedge mclk) begin
    if (sample_hold) begin
      held <= channel_valid ? ain_levels[lsb +: 8] : 8'h00;
    end
  end
  assign cmp_above = (held >= dac_code);
endmodule // sasc_afe_model

// File: verification/sar_adc_control_sequencer_tb.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
`include "sasc_map.svh"

module sar_adc_control_sequencer_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic standby_stop = 1'b0;
  logic wake_trigger_out = 1'b0;
  logic trigger_gen_enable = 1'b0;
  logic [47:0] ain_levels = 48'h0000_005a_0000;
  logic [7:0] reg_rdata;
  logic [7:0] dac_code;
  logic [2:0] channel_select;
  logic cmp_above;
  logic sample_hold;
  logic channel_valid;
  logic analog_in_disable;
  logic conv_busy;
  logic conv_done_irq;
  logic [7:0] d;
  int miscompares = 0;
  int samples_checked = 0;
  int irq_cnt = 0;
  int n;

  sasc_top i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_stop(standby_stop),
    .wake_trigger_out(wake_trigger_out), .trigger_gen_enable(trigger_gen_enable),
    .cmp_above(cmp_above), .dac_code(dac_code), .sample_hold(sample_hold),
    .channel_select(channel_select), .channel_valid(channel_valid),
    .analog_in_disable(analog_in_disable), .conv_busy(conv_busy),
    .conv_done_irq(conv_done_irq));

  sasc_afe_model i_afe (.mclk(mclk), .ain_levels(ain_levels), .dac_code(dac_code),
    .sample_hold(sample_hold), .channel_select(channel_select),
    .channel_valid(channel_valid), .cmp_above(cmp_above));

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    if (conv_done_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end

  // ********************
  // Bus and compare tasks.
  // ********************
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Read data stand for one cycle after the strobe; take them mid-cycle.
    @(negedge mclk);
    v = reg_rdata;
  endtask

  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    cmp(e, d);
  endtask

  task automatic cmp_range(input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
    end
  endtask

  // Waits for the completion pulse; a hang shows up as a count at the limit.
  task automatic wait_irq(input int lim, output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (conv_done_irq !== 1'b1 && c < lim);
  endtask

  task automatic quiet(input int c);
    int m;
    m = irq_cnt;
    repeat (c) @(posedge mclk);
    cmp_range(m, m, irq_cnt);
  endtask

  task automatic trig();
    @(posedge mclk);
    wake_trigger_out <= 1'b1;
    repeat (8) @(posedge mclk);
    wake_trigger_out <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ********************
  // Test sequence.
  // ********************
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    chk(`SASC_ADDR_CTL_ONE, `SASC_CTL_ONE_RST);
    chk(`SASC_ADDR_CTL_TWO, `SASC_CTL_TWO_RST);
    chk(`SASC_ADDR_STATUS, 8'h00);
    chk(8'h3c, 8'h00);
    cmp(8'h01, {7'h0, analog_in_disable});
    wr(`SASC_ADDR_CTL_ONE, 8'h82);
    quiet(300);
    chk(`SASC_ADDR_CTL_ONE, 8'h02);
    wr(`SASC_ADDR_CTL_ONE, 8'h06);
    wr(`SASC_ADDR_CTL_ONE, 8'he6);
    quiet(300);
    cmp(8'h00, {7'h0, channel_valid});
    chk(`SASC_ADDR_CTL_ONE, 8'h66);
    wr(`SASC_ADDR_CTL_ONE, 8'h06);
    $display("test reset and stop done");
    for (int k = 3; k <= 6; k++) begin
      wr(`SASC_ADDR_CTL_TWO, 8'h10 | 8'(k << 1));
      wr(`SASC_ADDR_CTL_ONE, 8'h02);
      wr(`SASC_ADDR_CTL_ONE, 8'h22);
      wr(`SASC_ADDR_CTL_ONE, 8'ha2);
      wait_irq(1400, n);
      cmp_range(156 << (k - 3), (156 << (k - 3)) + 4, n);
      chk(`SASC_ADDR_CTL_ONE, 8'h22);
      chk(`SASC_ADDR_STATUS, 8'h20);
      chk(`SASC_ADDR_RESULT, 8'h5a);
      chk(`SASC_ADDR_STATUS, 8'h00);
    end
    cmp(8'h00, {7'h0, analog_in_disable});
    cmp(8'h01, {7'h0, channel_valid});
    cmp(8'h00, {7'h0, conv_busy});
    wr(`SASC_ADDR_CTL_TWO, 8'h16);
    $display("test software start done");
    wr(`SASC_ADDR_CTL_ONE, 8'ha2);
    wait_irq(400, n);
    ain_levels <= 48'h0000_00a7_0000;
    wr(`SASC_ADDR_CTL_ONE, 8'ha2);
    repeat (10) @(posedge mclk);
    cmp(8'h01, {7'h0, conv_busy});
    chk(`SASC_ADDR_STATUS, 8'h10);
    chk(`SASC_ADDR_RESULT, 8'h5a);
    repeat (30) @(posedge mclk);
    wr(`SASC_ADDR_CTL_ONE, 8'ha2);
    wait_irq(400, n);
    cmp_range(156, 160, n);
    chk(`SASC_ADDR_RESULT, 8'ha7);
    $display("test restart done");
    ain_levels <= 48'h0000_0033_0000;
    wr(`SASC_ADDR_CTL_ONE, 8'ha2);
    repeat (40) @(posedge mclk);
    wr(`SASC_ADDR_CTL_ONE, 8'h02);
    quiet(300);
    chk(`SASC_ADDR_STATUS, 8'h00);
    chk(`SASC_ADDR_RESULT, 8'ha7);
    $display("test stop abort done");
    wr(`SASC_ADDR_CTL_ONE, 8'h42);
    trig();
    quiet(300);
    trigger_gen_enable <= 1'b1;
    trig();
    wait_irq(400, n);
    cmp_range(1, 399, n);
    chk(`SASC_ADDR_RESULT, 8'h33);
    trig();
    quiet(300);
    wr(`SASC_ADDR_CTL_ONE, 8'h02);
    trig();
    quiet(300);
    ain_levels <= 48'h0000_0081_0000;
    wr(`SASC_ADDR_CTL_ONE, 8'h42);
    trig();
    wait_irq(400, n);
    chk(`SASC_ADDR_RESULT, 8'h81);
    $display("test trigger done");
    wr(`SASC_ADDR_CTL_ONE, 8'h02);
    wr(`SASC_ADDR_CTL_ONE, 8'h22);
    wr(`SASC_ADDR_CTL_ONE, 8'ha2);
    repeat (40) @(posedge mclk);
    standby_stop <= 1'b1;
    repeat (5) @(posedge mclk);
    standby_stop <= 1'b0;
    quiet(300);
    chk(`SASC_ADDR_CTL_ONE, `SASC_CTL_ONE_RST);
    chk(`SASC_ADDR_CTL_TWO, `SASC_CTL_TWO_RST);
    chk(`SASC_ADDR_STATUS, 8'h00);
    $display("test standby done");
    end_sim();
  end

  // The full sequence takes about 5400 cycles; this limit leaves ample room.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end
endmodule // sar_adc_control_sequencer_tb
